/* inc/prox_irq_regs.vh */
// register offsets, field positions and reset values for the calibration status and irq block
`ifndef PROX_IRQ_REGS_VH
`define PROX_IRQ_REGS_VH
`define ADDR_CALIBRATION_STATUS 8'hDC
`define ADDR_INTERRUPT_ENABLE   8'hDD
`define ADDR_LOT_CODE_LOW       8'hE5
`define ADDR_LOT_CODE_HIGH      8'hE6
`define ADDR_FACTORY_TEST       8'hF9
`define BIT_CAL_DONE            0
`define BIT_OFFSET_AUTODEC      2
`define BIT_ZERO_DETECT_EN      1
`define BIT_CAL_IRQ_EN          2
`define BIT_SAT_IRQ_EN          3
`define BIT_PROX_IRQ_EN         4
`define BIT_PROX_MODE_SEL       5
`define RST_CALIBRATION_STATUS  8'h00
`define RST_INTERRUPT_ENABLE    8'h00
`define RST_FACTORY_TEST        8'h00
`define TEST_REQUIRED_VALUE     8'h07
`define LOT_CODE_LOW_DEFAULT    8'h5A
`define LOT_CODE_HIGH_DEFAULT   8'hA5
`endif

/* src/prox_calib_status_irq_regs.v */
// calibration status, interrupt enable, lot code and test registers with irq gating
// Contract
// - set offset flag on automatic offset decrement
// - clear offset flag by write-one or disable
// - calibration done bit mirrors calibration irq flag
// - done bit clears only with calibration flag
// - mode bit selects level or state proximity
// - proximity flag forwarded only when enabled
// - separate saturation and calibration enables, reset zero
// - zero detect enable gates zero detect source
// - lot code bytes read only at E5/E6
// - decrement low offset when result reaches zero
// - calibration flag set when calibration completes
`timescale 1ns/1ps
`include "prox_irq_regs.vh"
module prox_calib_status_irq_regs #(
  parameter [7:0] LOT_LOW  = `LOT_CODE_LOW_DEFAULT,  // arbitrary value
  parameter [7:0] LOT_HIGH = `LOT_CODE_HIGH_DEFAULT  // arbitrary value
) (
  input  wire       sys_clk,
  input  wire       rst,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire       auto_offset_decrement_en,
  input  wire       prox_result_zero,
  input  wire       calibration_complete,
  input  wire       calibration_irq_clear,
  input  wire       prox_level_cond,
  input  wire       prox_state_cond,
  input  wire       prox_irq_clear,
  input  wire       saturation_event,
  input  wire       zero_detect_event,
  output wire       offset_decrement,
  output wire       calibration_irq_flag,
  output wire       prox_irq_flag,
  output wire       prox_irq_mode_sel,
  output wire [7:0] factory_test_setting,
  output wire       irq_n
);
  // interrupt enable register, current and next value
  reg  [7:0] inten_q;
  reg  [7:0] inten_d;

  // test register, current and next value
  reg  [7:0] ftest_q;
  reg  [7:0] ftest_d;

  // offset decremented flag, current and next value
  reg        autodec_q;
  reg        autodec_d;

  // calibration flag, current and next value
  reg        cal_q;
  reg        cal_d;

  // proximity flag, current and next value
  reg        prox_q;
  reg        prox_d;

  // read data next value
  reg  [7:0] rdata_d;

  // decoded write strobes
  wire       wr_cs;
  wire       wr_ie;
  wire       wr_ft;

  // flag set and clear conditions
  wire       autodec_set;
  wire       autodec_clr;
  wire       prox_set;

  // interrupt sources, their enables and the gated view, one bit per source
  wire [3:0] irq_src;
  wire [3:0] irq_en;
  wire [3:0] irq_gated;
  wire       irq_any;

  // loop index for the per-source gating
  genvar     g;

  // write decode, one strobe per writable register
  assign wr_cs = reg_wr && (reg_addr == `ADDR_CALIBRATION_STATUS);
  assign wr_ie = reg_wr && (reg_addr == `ADDR_INTERRUPT_ENABLE);
  assign wr_ft = reg_wr && (reg_addr == `ADDR_FACTORY_TEST);

  // decrement request to the offset register when the result hits zero;
  // it stays high while the result sits at zero, and the offset register
  // outside decides how often it actually steps
  assign offset_decrement = auto_offset_decrement_en & prox_result_zero;

  // offset flag set term, the same event that steps the offset
  assign autodec_set = offset_decrement;

  // offset flag clear terms: write one to the bit, or turn the feature off
  assign autodec_clr = (wr_cs & reg_wdata[`BIT_OFFSET_AUTODEC]) | ~auto_offset_decrement_en;

  // proximity condition picked by the mode bit
  assign prox_irq_mode_sel = inten_q[`BIT_PROX_MODE_SEL];
  assign prox_set          = prox_irq_mode_sel ? prox_state_cond : prox_level_cond;

  // interrupt enable register, written as a whole byte; reserved bits keep
  // what the host writes so that a read shows exactly what was programmed
  always @* begin
    inten_d = inten_q;
    if (wr_ie) begin
      inten_d = reg_wdata;
    end
  end

  // test register, a plain byte the host must load during configuration
  always @* begin
    ftest_d = ftest_q;
    if (wr_ft) begin
      ftest_d = reg_wdata;
    end
  end

  // offset flag: set wins over both clears, so an event that lands in the
  // clearing cycle is not lost; the disable clear cannot race the set,
  // because the set itself needs the feature enabled
  always @* begin
    autodec_d = autodec_q;
    if (autodec_set) begin
      autodec_d = 1'h1;
    end else if (autodec_clr) begin
      autodec_d = 1'h0;
    end
  end

  // calibration flag: set by completion, cleared only by the main status
  // clear; writes to the calibration status byte never reach it
  always @* begin
    cal_d = cal_q;
    if (calibration_complete) begin
      cal_d = 1'h1;
    end else if (calibration_irq_clear) begin
      cal_d = 1'h0;
    end
  end

  // proximity flag: set by the condition the mode bit picked, set wins
  always @* begin
    prox_d = prox_q;
    if (prox_set) begin
      prox_d = 1'h1;
    end else if (prox_irq_clear) begin
      prox_d = 1'h0;
    end
  end

  // all control state on one synchronous reset
  always @(posedge sys_clk) begin
    if (rst) begin
      inten_q   <= `RST_INTERRUPT_ENABLE;
      ftest_q   <= `RST_FACTORY_TEST;
      autodec_q <= 1'h0;
      cal_q     <= 1'h0;
      prox_q    <= 1'h0;
    end else begin
      inten_q   <= inten_d;
      ftest_q   <= ftest_d;
      autodec_q <= autodec_d;
      cal_q     <= cal_d;
      prox_q    <= prox_d;
    end
  end

  // flag and register outputs, straight from the flip-flops
  assign calibration_irq_flag = cal_q;
  assign prox_irq_flag        = prox_q;
  assign factory_test_setting = ftest_q;

  // sources in enable-bit order: zero detect, calibration, saturation, proximity
  assign irq_src = {prox_q, saturation_event, cal_q, zero_detect_event};

  // enables sit on bits 4 down to 1 of the enable register
  assign irq_en = inten_q[`BIT_PROX_IRQ_EN:`BIT_ZERO_DETECT_EN];

  // gate each source by its own enable and by nothing else
  generate
    for (g = 0; g < 4; g = g + 1) begin : gate_src
      assign irq_gated[g] = irq_src[g] & irq_en[g];
    end
  endgenerate

  // any enabled source pulls the active-low line
  assign irq_any = |irq_gated;
  assign irq_n   = ~irq_any;

  // read mux; the status byte is built from the live flags, so bit 0 is the
  // calibration flag itself and never a second copy that could drift
  always @* begin
    rdata_d = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        `ADDR_CALIBRATION_STATUS: begin
          rdata_d                      = 8'h00;
          rdata_d[`BIT_OFFSET_AUTODEC] = autodec_q;
          rdata_d[`BIT_CAL_DONE]       = cal_q;
        end
        `ADDR_INTERRUPT_ENABLE: begin
          rdata_d = inten_q;
        end
        `ADDR_LOT_CODE_LOW: begin
          rdata_d = LOT_LOW;
        end
        `ADDR_LOT_CODE_HIGH: begin
          rdata_d = LOT_HIGH;
        end
        `ADDR_FACTORY_TEST: begin
          rdata_d = ftest_q;
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  // registered read data, holds until the next read
  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // the lot code bytes have no write path at all, so a stray write to them
  // or to an unmapped address simply falls through the write decode above;
  // likewise bit 0 of the status byte has no write term, so the host can
  // only clear it through the main status clear that drops the flag itself
endmodule

/* sim/prox_irq_sva.sv */
// checker on the register block ports
`timescale 1ns/1ps
module prox_irq_sva #(parameter [7:0] LOT_LOW = 8'h5A) (
  input wire sys_clk, rst, reg_wr, reg_rd, auto_offset_decrement_en, prox_result_zero,
  input wire offset_decrement, calibration_complete, calibration_irq_clear,
  input wire calibration_irq_flag, prox_irq_mode_sel,
  input wire [7:0] reg_addr, reg_wdata, reg_rdata, factory_test_setting);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // a write cycle to one register
  sequence s_wr(x); reg_wr && reg_addr == x; endsequence
  property p_od; offset_decrement == (auto_offset_decrement_en & prox_result_zero); endproperty
  a_od: assert property (p_od) else $error("decrement");
  property p_cs; calibration_complete |=> calibration_irq_flag; endproperty
  a_cs: assert property (p_cs) else $error("cal set");
  property p_cc;
    calibration_irq_clear && !calibration_complete |=> !calibration_irq_flag;
  endproperty
  a_cc: assert property (p_cc) else $error("cal clear");
  property p_ch; calibration_irq_flag && !calibration_irq_clear |=> calibration_irq_flag; endproperty
  a_ch: assert property (p_ch) else $error("cal hold");
  property p_md; s_wr(8'hDD) |=> prox_irq_mode_sel == $past(reg_wdata[5]); endproperty
  a_md: assert property (p_md) else $error("mode");
  property p_ts; s_wr(8'hF9) |=> factory_test_setting == $past(reg_wdata); endproperty
  a_ts: assert property (p_ts) else $error("test");
  property p_lo; reg_rd && reg_addr == 8'hE5 |=> reg_rdata == LOT_LOW; endproperty
  a_lo: assert property (p_lo) else $error("lot");
  property p_un; reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00; endproperty
  a_un: assert property (p_un) else $error("unmapped");
endmodule
bind prox_calib_status_irq_regs prox_irq_sva #(.LOT_LOW(LOT_LOW)) i_sva (.*);

/* sim/host_model.sv */
// host model driving the device register port
`timescale 1ns/1ps
module host_model (input wire sys_clk, input wire [7:0] reg_rdata,
  output reg reg_wr = 1'b0, output reg reg_rd = 1'b0,
  output reg [7:0] reg_addr = 8'h00, output reg [7:0] reg_wdata = 8'h00);
  // one access per call, caller keeps reserved fields zero and test byte 0x07
  task xfer(input w, input [7:0] a, input [7:0] d, output [7:0] q);
    begin
      reg_wr <= w; reg_rd <= !w; reg_addr <= a; reg_wdata <= d;
      @(posedge sys_clk); reg_wr <= 1'b0; reg_rd <= 1'b0; reg_wdata <= ~d;
      @(posedge sys_clk); q = reg_rdata;
    end
  endtask
endmodule

/* sim/prox_calib_status_irq_regs_tb.sv */
// self-checking bench for the calibration status and irq registers
`timescale 1ns/1ps
module prox_calib_status_irq_regs_tb;
  reg sys_clk = 1'b0, rst = 1'b1;
  reg [8:0] ev = 9'h000; // zero, sat, pclr, state, level, cclr, cdone, rzero, auto
  wire [7:0] a, wd, rd, fts;
  wire w, r, od, cf, pf, pm, irq_n;
  integer num_errors = 0, n_tests = 0, cyc = 0;
  reg [7:0] v;
  host_model i_host (.sys_clk(sys_clk), .reg_rdata(rd), .reg_wr(w), .reg_rd(r), .reg_addr(a),
    .reg_wdata(wd));
  prox_calib_status_irq_regs i_dut (.sys_clk(sys_clk), .rst(rst), .reg_wr(w), .reg_rd(r),
    .reg_addr(a), .reg_wdata(wd), .reg_rdata(rd), .auto_offset_decrement_en(ev[0]),
    .prox_result_zero(ev[1]), .calibration_complete(ev[2]), .calibration_irq_clear(ev[3]),
    .prox_level_cond(ev[4]), .prox_state_cond(ev[5]), .prox_irq_clear(ev[6]),
    .saturation_event(ev[7]), .zero_detect_event(ev[8]), .offset_decrement(od),
    .calibration_irq_flag(cf), .prox_irq_flag(pf), .prox_irq_mode_sel(pm),
    .factory_test_setting(fts), .irq_n(irq_n));
  task chk(input [7:0] g, input [7:0] e); begin n_tests = n_tests + 1;
    if (g !== e) begin num_errors = num_errors + 1; $display("Error %0t %h %h", $time, g, e); end
  end endtask
  task wr(input [7:0] ad, input [7:0] d); i_host.xfer(1'b1, ad, d, v); endtask
  task rc(input [7:0] ad, input [7:0] e); begin i_host.xfer(1'b0, ad, 8'h00, v);
    chk(v, e); end endtask
  task ps(input [8:0] e); begin ev <= e; @(posedge sys_clk); end endtask
  task t_regs; begin wr(8'hDD, 8'h3E); rc(8'hDD, 8'h3E); chk(pm, 1'b1);
    wr(8'hF9, 8'h07); chk(fts, 8'h07); wr(8'hE5, 8'h00); rc(8'hE5, 8'h5A);
    rc(8'hE6, 8'hA5); rc(8'h00, 8'h00); end endtask
  task t_cal; begin wr(8'hDD, 8'h04); ps(9'h004); ps(9'h000); rc(8'hDC, 8'h01);
    chk(cf, 1'b1);
    chk(irq_n, 1'b0); wr(8'hDC, 8'h01); rc(8'hDC, 8'h01);
    ps(9'h008); ps(9'h000); rc(8'hDC, 8'h00); chk(irq_n, 1'b1); end endtask
  task t_src; begin wr(8'hDD, 8'h00); ps(9'h180); chk(irq_n, 1'b1);
    wr(8'hDD, 8'h02); chk(irq_n, 1'b0); wr(8'hDD, 8'h08); chk(irq_n, 1'b0);
    wr(8'hDD, 8'h04); chk(irq_n, 1'b1); ps(9'h000); end endtask
  task t_off; begin ps(9'h003); chk(od, 1'b1); ps(9'h001); rc(8'hDC, 8'h04);
    wr(8'hDC, 8'h04); rc(8'hDC, 8'h00); ps(9'h003); ps(9'h001); ps(9'h000);
    rc(8'hDC, 8'h00); end endtask
  task t_prox; begin wr(8'hDD, 8'h10); ps(9'h010); ps(9'h000); chk(pf, 1'b1);
    chk(irq_n, 1'b0); ps(9'h040); ps(9'h000); chk(pf, 1'b0);
    wr(8'hDD, 8'h30); ps(9'h010); ps(9'h000); chk(pf, 1'b0);
    ps(9'h020); ps(9'h000); chk(pf, 1'b1); chk(irq_n, 1'b0);
    ps(9'h040); ps(9'h000); chk(pf, 1'b0); end endtask
  task stop_test; begin
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish; end endtask
  initial forever #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin cyc = cyc + 1;
    if (cyc == 500) begin num_errors = num_errors + 1; stop_test; end end
  initial begin repeat (3) @(posedge sys_clk); rst <= 1'b0;
    t_regs; t_cal; t_src; t_off; t_prox; stop_test; end
endmodule
